/* File: logic/dip_act_if.sv */
// Interface joining one activity detector to the power selector.
interface dip_act_if;
  logic sig;
  logic run;
  logic active;
  modport det (input sig, input run, output active);
  modport user (output sig, output run, input active);
endinterface

/* File: logic/dip_activity_detect.sv */
// Toggle watchdog that flags a sync or clock input as active.
module dip_activity_detect #(
  parameter int TIMEOUT = dip_pkg::TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  dip_act_if.det ch
);
  logic prev_r;
  logic [dip_pkg::CNT_W-1:0] idle_cnt_r;
  logic active_r;
  logic toggle;

  // Any change of level counts as activity.
  assign toggle = ch.sig != prev_r;
  assign ch.active = active_r;

  // Previous level of the watched signal.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prev_r <= 1'b0;
    else
      prev_r <= ch.sig;
  end

  // Idle counter; it only runs while run is on and the channel is active, clears on a toggle or with run off, else holds.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      idle_cnt_r <= '0;
    else if (!ch.run || toggle)
      idle_cnt_r <= '0;
    else if (active_r)
      idle_cnt_r <= idle_cnt_r + 1'b1;
  end

  // Active is set by a toggle and dropped once the idle time reaches the timeout.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      active_r <= 1'b0;
    else if (!ch.run)
      active_r <= 1'b0;
    else if (toggle)
      active_r <= 1'b1;
    else if (idle_cnt_r == dip_pkg::CNT_W'(TIMEOUT - 1))
      active_r <= 1'b0;
  end
endmodule

/* File: logic/dip_pkg.sv */
// Shared constants for the dual interface power select block.
package dip_pkg;
  // Register offsets on the two-wire serial register port.
  localparam logic [7:0] REG_OVR_SEL_ADDR = 8'h0f;
  localparam logic [7:0] REG_PWR_CTL_ADDR = 8'h14;
  localparam logic [7:0] REG_DET_STAT_ADDR = 8'h15;
  // Reset values of the writable registers.
  localparam logic [7:0] OVR_SEL_RESET = 8'h00;
  localparam logic [7:0] PWR_CTL_RESET = 8'h02;
  // Field positions in the override/select register.
  localparam int OVR_THRESH_MSB = 7;
  localparam int OVR_THRESH_LSB = 3;
  localparam int OVR_BIT = 2;
  localparam int SEL_BIT = 1;
  localparam int FMT_BIT = 0;
  // Field positions in the power control register.
  localparam int PWR_EN_BIT = 1;
  // Field positions in the detect status register.
  localparam int STAT_HSYNC_BIT = 7;
  localparam int STAT_GSYNC_BIT = 6;
  localparam int STAT_VSYNC_BIT = 5;
  localparam int STAT_LCLK_BIT = 4;
  localparam int STAT_DE_LOCK_BIT = 3;
  // Activity channel indices.
  localparam int CH_HSYNC = 0;
  localparam int CH_VSYNC = 1;
  localparam int CH_GSYNC = 2;
  localparam int CH_LCLK = 3;
  localparam int NUM_CH = 4;
  // Timing: activity timeout and pixel-valid run length.
  localparam longint CLK_HZ = 40000000;
  localparam longint TIMEOUT_MS = 100;
  localparam int TIMEOUT_CYC = int'((CLK_HZ * TIMEOUT_MS) / 1000);
  localparam int CNT_W = 22;
  localparam logic [5:0] DE_RUN_COUNT = 6'h20;
  // Power modes, one-hot.
  typedef enum logic [4:0] {
    MODE_ABS_PD = 5'h01,
    MODE_SEEK = 5'h02,
    MODE_DIGITAL = 5'h04,
    MODE_ANA_444 = 5'h08,
    MODE_ANA_422 = 5'h10
  } dip_mode_t;
endpackage

/* File: logic/dip_power_select.sv */
// Interface detection, active interface choice and power mode control.
module dip_power_select #(
  parameter int TIMEOUT_CYC = dip_pkg::TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic green_embedded_sync,
  input wire logic link_clk_in,
  input wire logic pixel_valid_flag,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rd_data,
  output logic [4:0] slicer_threshold,
  output logic [4:0] power_mode,
  output logic pwr_serial_bus,
  output logic pwr_link_clk_detect,
  output logic pwr_analog_detect,
  output logic pwr_green_slicer,
  output logic pwr_reference,
  output logic pwr_analog_path,
  output logic pwr_digital_path,
  output logic out_red_en,
  output logic out_green_en,
  output logic out_blue_en,
  output logic digital_video_locked
);
  // Writable registers and the read data register.
  logic [7:0] ovr_sel_r;
  logic [7:0] pwr_ctl_r;
  logic [7:0] rd_data_r;

  // Mode state and its next value.
  dip_pkg::dip_mode_t mode_r;
  dip_pkg::dip_mode_t mode_nxt;

  // Pixel-valid run detection for the second stage of digital detection.
  logic de_prev_r;
  logic [5:0] de_cnt_r;
  logic de_lock_r;

  // Power enables, all registered.
  logic pwr_link_det_r;
  logic pwr_ana_det_r;
  logic pwr_slicer_r;
  logic pwr_ref_r;
  logic pwr_ana_path_r;
  logic pwr_dig_path_r;
  logic red_en_r;
  logic green_en_r;
  logic blue_en_r;

  // Decoded control and detect terms.
  logic power_on;
  logic override_on;
  logic select_digital;
  logic format_422;
  logic [dip_pkg::NUM_CH-1:0] ch_sig;
  logic [dip_pkg::NUM_CH-1:0] ch_active;
  logic analog_detected;
  logic digital_detected;
  logic de_rise;

  // Field extraction used for the mode decision terms.
  function automatic logic reg_bit(input logic [7:0] val, input int pos);
    reg_bit = val[pos];
  endfunction

  // Picks the analog mode that matches the format bit.
  function automatic dip_pkg::dip_mode_t analog_mode(input logic fmt422);
    if (fmt422)
      analog_mode = dip_pkg::MODE_ANA_422;
    else
      analog_mode = dip_pkg::MODE_ANA_444;
  endfunction

  assign power_on = reg_bit(pwr_ctl_r, dip_pkg::PWR_EN_BIT);
  assign override_on = reg_bit(ovr_sel_r, dip_pkg::OVR_BIT);
  assign select_digital = reg_bit(ovr_sel_r, dip_pkg::SEL_BIT);
  assign format_422 = reg_bit(ovr_sel_r, dip_pkg::FMT_BIT);

  // Watched inputs, one per activity channel.
  assign ch_sig[dip_pkg::CH_HSYNC] = hsync_in;
  assign ch_sig[dip_pkg::CH_VSYNC] = vsync_in;
  assign ch_sig[dip_pkg::CH_GSYNC] = green_embedded_sync;
  assign ch_sig[dip_pkg::CH_LCLK] = link_clk_in;

  // One watchdog per channel. They run on the power enable bit, which is set in every mode except
  // absolute power-down, so the link clock watchdog keeps going with the digital path off.
  dip_act_if act_ch [dip_pkg::NUM_CH] ();
  genvar gi;
  generate
    for (gi = 0; gi < dip_pkg::NUM_CH; gi++)
    begin : g_ch
      assign act_ch[gi].sig = ch_sig[gi];
      assign act_ch[gi].run = power_on;
      assign ch_active[gi] = act_ch[gi].active;
      dip_activity_detect #(
        .TIMEOUT(TIMEOUT_CYC)
      ) u_det (
        .clk(clk),
        .rst(rst),
        .ch(act_ch[gi])
      );
    end
  endgenerate

  // Any one analog sync counts; the digital side trusts the link clock alone.
  assign analog_detected = ch_active[dip_pkg::CH_HSYNC] |
                           ch_active[dip_pkg::CH_VSYNC] |
                           ch_active[dip_pkg::CH_GSYNC];
  assign digital_detected = ch_active[dip_pkg::CH_LCLK];

  // Mode decision, in priority order: power-down, override, automatic.
  always_comb
  begin
    mode_nxt = dip_pkg::MODE_SEEK;
    if (!power_on)
      mode_nxt = dip_pkg::MODE_ABS_PD;
    else if (override_on)
    begin
      if (select_digital)
        mode_nxt = dip_pkg::MODE_DIGITAL;
      else
        mode_nxt = analog_mode(format_422);
    end
    else if (analog_detected && digital_detected)
    begin
      if (select_digital)
        mode_nxt = dip_pkg::MODE_DIGITAL;
      else
        mode_nxt = analog_mode(format_422);
    end
    else if (digital_detected)
      mode_nxt = dip_pkg::MODE_DIGITAL;
    else if (analog_detected)
      mode_nxt = analog_mode(format_422);
    else
      mode_nxt = dip_pkg::MODE_SEEK;
  end

  // Mode register; one cycle behind the detect and control inputs.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mode_r <= dip_pkg::MODE_SEEK;
    else
      mode_r <= mode_nxt;
  end

  // Power enables per mode. Each process sees the same mode so the set stays consistent.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pwr_link_det_r <= 1'b1;
      pwr_ana_det_r <= 1'b1;
      pwr_slicer_r <= 1'b1;
      pwr_ref_r <= 1'b0;
      pwr_ana_path_r <= 1'b0;
      pwr_dig_path_r <= 1'b0;
      red_en_r <= 1'b0;
      green_en_r <= 1'b0;
      blue_en_r <= 1'b0;
    end
    else
    begin
      case (mode_nxt)
        dip_pkg::MODE_ABS_PD:
        begin
          pwr_link_det_r <= 1'b0;
          pwr_ana_det_r <= 1'b0;
          pwr_slicer_r <= 1'b0;
          pwr_ref_r <= 1'b0;
          pwr_ana_path_r <= 1'b0;
          pwr_dig_path_r <= 1'b0;
          red_en_r <= 1'b0;
          green_en_r <= 1'b0;
          blue_en_r <= 1'b0;
        end
        dip_pkg::MODE_SEEK:
        begin
          pwr_link_det_r <= 1'b1;
          pwr_ana_det_r <= 1'b1;
          pwr_slicer_r <= 1'b1;
          pwr_ref_r <= 1'b0;
          pwr_ana_path_r <= 1'b0;
          pwr_dig_path_r <= 1'b0;
          red_en_r <= 1'b0;
          green_en_r <= 1'b0;
          blue_en_r <= 1'b0;
        end
        dip_pkg::MODE_DIGITAL:
        begin
          pwr_link_det_r <= 1'b1;
          pwr_ana_det_r <= 1'b1;
          pwr_slicer_r <= 1'b1;
          pwr_ref_r <= 1'b1;
          pwr_ana_path_r <= 1'b0;
          pwr_dig_path_r <= 1'b1;
          red_en_r <= 1'b1;
          green_en_r <= 1'b1;
          blue_en_r <= 1'b1;
        end
        dip_pkg::MODE_ANA_444:
        begin
          pwr_link_det_r <= 1'b1;
          pwr_ana_det_r <= 1'b1;
          pwr_slicer_r <= 1'b1;
          pwr_ref_r <= 1'b1;
          pwr_ana_path_r <= 1'b1;
          pwr_dig_path_r <= 1'b0;
          red_en_r <= 1'b1;
          green_en_r <= 1'b1;
          blue_en_r <= 1'b1;
        end
        dip_pkg::MODE_ANA_422:
        begin
          pwr_link_det_r <= 1'b1;
          pwr_ana_det_r <= 1'b1;
          pwr_slicer_r <= 1'b1;
          pwr_ref_r <= 1'b1;
          pwr_ana_path_r <= 1'b1;
          pwr_dig_path_r <= 1'b0;
          red_en_r <= 1'b1;
          green_en_r <= 1'b1;
          blue_en_r <= 1'b0;
        end
        default:
        begin
          pwr_link_det_r <= 1'b1;
          pwr_ana_det_r <= 1'b1;
          pwr_slicer_r <= 1'b1;
          pwr_ref_r <= 1'b0;
          pwr_ana_path_r <= 1'b0;
          pwr_dig_path_r <= 1'b0;
          red_en_r <= 1'b0;
          green_en_r <= 1'b0;
          blue_en_r <= 1'b0;
        end
      endcase
    end
  end

  // Rising edges of the pixel-valid flag mark one data-enable period each.
  assign de_rise = pixel_valid_flag && !de_prev_r;

  // Previous pixel-valid level; it is only meaningful while the digital path is up.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      de_prev_r <= 1'b0;
    else
      de_prev_r <= pixel_valid_flag;
  end

  // Second detection stage. The run restarts whenever the link clock is lost or the
  // digital path drops, so only an unbroken run of periods completes detection.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      de_cnt_r <= 6'h00;
    else if (mode_nxt != dip_pkg::MODE_DIGITAL || !digital_detected)
      de_cnt_r <= 6'h00;
    else if (de_rise && de_cnt_r != dip_pkg::DE_RUN_COUNT)
      de_cnt_r <= de_cnt_r + 6'h01;
  end

  // Lock flag. It follows the mode decision, not the registered path enable, so it drops
  // on the same edge as the digital path and never outlives it.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      de_lock_r <= 1'b0;
    else if (mode_nxt != dip_pkg::MODE_DIGITAL || !digital_detected)
      de_lock_r <= 1'b0;
    else if (de_cnt_r == dip_pkg::DE_RUN_COUNT)
      de_lock_r <= 1'b1;
  end

  // Register writes. Status is read-only, so writes to it and unmapped offsets are dropped.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ovr_sel_r <= dip_pkg::OVR_SEL_RESET;
    else if (reg_wr && reg_addr == dip_pkg::REG_OVR_SEL_ADDR)
      ovr_sel_r <= reg_wdata;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pwr_ctl_r <= dip_pkg::PWR_CTL_RESET;
    else if (reg_wr && reg_addr == dip_pkg::REG_PWR_CTL_ADDR)
      pwr_ctl_r <= reg_wdata;
  end

  // Read data follows the address by one cycle; unmapped offsets read as zero.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rd_data_r <= 8'h00;
    else
    begin
      case (reg_addr)
        dip_pkg::REG_OVR_SEL_ADDR:
          rd_data_r <= ovr_sel_r;
        dip_pkg::REG_PWR_CTL_ADDR:
          rd_data_r <= pwr_ctl_r;
        dip_pkg::REG_DET_STAT_ADDR:
        begin
          rd_data_r <= 8'h00;
          rd_data_r[dip_pkg::STAT_HSYNC_BIT] <= ch_active[dip_pkg::CH_HSYNC];
          rd_data_r[dip_pkg::STAT_GSYNC_BIT] <= ch_active[dip_pkg::CH_GSYNC];
          rd_data_r[dip_pkg::STAT_VSYNC_BIT] <= ch_active[dip_pkg::CH_VSYNC];
          rd_data_r[dip_pkg::STAT_LCLK_BIT] <= ch_active[dip_pkg::CH_LCLK];
          rd_data_r[dip_pkg::STAT_DE_LOCK_BIT] <= de_lock_r;
        end
        default:
          rd_data_r <= 8'h00;
      endcase
    end
  end

  // Outputs. The serial bus is never switched off, even in absolute power-down.
  assign reg_rd_data = rd_data_r;
  assign slicer_threshold = ovr_sel_r[dip_pkg::OVR_THRESH_MSB:dip_pkg::OVR_THRESH_LSB];
  assign power_mode = mode_r;
  assign pwr_serial_bus = 1'b1;
  assign pwr_link_clk_detect = pwr_link_det_r;
  assign pwr_analog_detect = pwr_ana_det_r;
  assign pwr_green_slicer = pwr_slicer_r;
  assign pwr_reference = pwr_ref_r;
  assign pwr_analog_path = pwr_ana_path_r;
  assign pwr_digital_path = pwr_dig_path_r;
  assign out_red_en = red_en_r;
  assign out_green_en = green_en_r;
  assign out_blue_en = blue_en_r;
  assign digital_video_locked = de_lock_r;
endmodule

/* File: verif/dip_power_select_properties.sv */
// Port-level assertions for the dual interface power select block.
module dip_power_select_properties #(
  parameter int TIMEOUT_CYC = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic green_embedded_sync,
  input wire logic link_clk_in,
  input wire logic pixel_valid_flag,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rd_data,
  input wire logic [4:0] slicer_threshold,
  input wire logic [4:0] power_mode,
  input wire logic pwr_serial_bus,
  input wire logic pwr_link_clk_detect,
  input wire logic pwr_analog_detect,
  input wire logic pwr_green_slicer,
  input wire logic pwr_reference,
  input wire logic pwr_analog_path,
  input wire logic pwr_digital_path,
  input wire logic out_red_en,
  input wire logic out_green_en,
  input wire logic out_blue_en,
  input wire logic digital_video_locked
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] en;
  logic [7:0] ovr_r;
  logic pwr_r;
  logic [3:0] prev_r;
  int idle_r;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Block enables other than the serial bus in one vector, detectors first and colour outputs last.
  assign en = {pwr_link_clk_detect, pwr_analog_detect, pwr_green_slicer, pwr_reference,
               pwr_analog_path, pwr_digital_path, out_red_en, out_green_en, out_blue_en};

  // Shadow copies of the control registers, so the checks can predict the chosen mode.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ovr_r <= dip_pkg::OVR_SEL_RESET;
      pwr_r <= dip_pkg::PWR_CTL_RESET[1];
    end
    else if (reg_wr && reg_addr == dip_pkg::REG_OVR_SEL_ADDR)
      ovr_r <= reg_wdata;
    else if (reg_wr && reg_addr == dip_pkg::REG_PWR_CTL_ADDR)
      pwr_r <= reg_wdata[1];
  end

  // Cycles since any sync or link clock input last moved; saturates past the timeout.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prev_r <= 4'h0;
      idle_r <= 0;
    end
    else
    begin
      prev_r <= {hsync_in, vsync_in, green_embedded_sync, link_clk_in};
      if (prev_r != {hsync_in, vsync_in, green_embedded_sync, link_clk_in})
        idle_r <= 0;
      else if (idle_r < TIMEOUT_CYC + 8)
        idle_r <= idle_r + 1;
    end
  end

  abs_pd_off_a: assert property (power_mode == dip_pkg::MODE_ABS_PD
    |-> en == 9'h000 && pwr_serial_bus && !digital_video_locked)
    else $error("power-down left a block on");
  seek_power_a: assert property (power_mode == dip_pkg::MODE_SEEK |-> en == 9'h1c0)
    else $error("seek mode enables wrong");
  digital_power_a: assert property (power_mode == dip_pkg::MODE_DIGITAL |-> en == 9'h1ef)
    else $error("digital mode enables wrong");
  analog_full_a: assert property (power_mode == dip_pkg::MODE_ANA_444 |-> en == 9'h1f7)
    else $error("analog full mode enables wrong");
  analog_half_a: assert property (power_mode == dip_pkg::MODE_ANA_422 |-> en == 9'h1f6)
    else $error("analog half mode enables wrong");
  pd_write_a: assert property (reg_wr && reg_addr == dip_pkg::REG_PWR_CTL_ADDR
    && !reg_wdata[1] ##1 !reg_wr |=> power_mode == dip_pkg::MODE_ABS_PD)
    else $error("power-down write not obeyed");
  force_digital_a: assert property (reg_wr && reg_addr == dip_pkg::REG_OVR_SEL_ADDR
    && reg_wdata[2:1] == 2'b11 && pwr_r ##1 !reg_wr |=> power_mode == dip_pkg::MODE_DIGITAL)
    else $error("override to digital not obeyed");
  hsync_analog_a: assert property ($changed(hsync_in) && pwr_r && $past(pwr_r, 4)
    && ovr_r[2:1] == 2'b00 && !reg_wr ##1 !reg_wr |=> power_mode ==
    (ovr_r[0] ? dip_pkg::MODE_ANA_422 : dip_pkg::MODE_ANA_444))
    else $error("sync activity did not select analog");
  idle_seek_a: assert property (idle_r == TIMEOUT_CYC + 4 && pwr_r && !ovr_r[2]
    && !$past(reg_wr) |-> power_mode == dip_pkg::MODE_SEEK)
    else $error("inactivity did not return to seek");
  lock_path_a: assert property ($rose(digital_video_locked) |-> pwr_digital_path)
    else $error("lock without digital path");
  one_iface_a: assert property ($onehot(power_mode) && !(pwr_analog_path && pwr_digital_path))
    else $error("two interfaces powered");
endmodule

bind dip_power_select dip_power_select_properties #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_chk (.*);

/* File: verif/dip_power_select_tb.sv */
// Self-checking bench for the dual interface power select block.
module dip_power_select_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TMO = 16;
  localparam logic [7:0] A_OVR = dip_pkg::REG_OVR_SEL_ADDR;
  localparam logic [7:0] A_PWR = dip_pkg::REG_PWR_CTL_ADDR;
  localparam logic [7:0] A_STA = dip_pkg::REG_DET_STAT_ADDR;
  logic clk, rst, reg_wr, hsync_in, vsync_in, green_embedded_sync, link_clk_in;
  logic pixel_valid_flag, pwr_serial_bus, pwr_link_clk_detect, pwr_analog_detect;
  logic pwr_green_slicer, pwr_reference, pwr_analog_path, pwr_digital_path;
  logic out_red_en, out_green_en, out_blue_en, digital_video_locked;
  logic [7:0] reg_addr, reg_wdata, reg_rd_data;
  logic [4:0] slicer_threshold, power_mode, run;
  int bad_count, cmp_count;

  dip_power_select #(.TIMEOUT_CYC(TMO)) i_dut (.*);
  dip_src_model i_src (.*);

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // The write pulse lasts one edge; three more edges let the mode settle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(3);
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    tick(2);
    chk(what, reg_rd_data, exp);
  endtask

  // Bounded wait for a mode; running out of the bound ends the run.
  task automatic wmode(input logic [4:0] m, input int lim);
    int i;
    for (i = 0; i < lim && power_mode !== m; i++)
      tick(1);
    chk("power_mode", {3'h0, power_mode}, {3'h0, m});
    if (power_mode !== m)
      report_and_stop();
  endtask

  task automatic t_regs();
    chk("power_mode", {3'h0, power_mode}, {3'h0, dip_pkg::MODE_SEEK});
    rchk("override reg", A_OVR, dip_pkg::OVR_SEL_RESET);
    rchk("power reg", A_PWR, dip_pkg::PWR_CTL_RESET);
    wr(A_OVR, 8'ha8);
    chk("slicer", {3'h0, slicer_threshold}, 8'h15);
    rchk("override reg", A_OVR, 8'ha8);
    wr(A_OVR, dip_pkg::OVR_SEL_RESET);
    wr(A_STA, 8'hff);
    rchk("status", A_STA, 8'h00);
    rchk("unmapped", 8'h33, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_analog();
    logic [7:0] bits [3] = '{8'h80, 8'h20, 8'h40};
    for (int c = 0; c < 3; c++)
    begin
      run = 5'(1 << c);
      wmode(dip_pkg::MODE_ANA_444, 8);
      rchk("sync status", A_STA, bits[c]);
      run = 5'h00;
      wmode(dip_pkg::MODE_SEEK, TMO + 8);
      rchk("sync status", A_STA, 8'h00);
    end
    run = 5'h01;
    wr(A_OVR, 8'h01);
    wmode(dip_pkg::MODE_ANA_422, 8);
    run = 5'h00;
    wr(A_OVR, 8'h00);
    wmode(dip_pkg::MODE_SEEK, TMO + 8);
    $display("test analog done");
  endtask

  task automatic t_link();
    int i;
    run = 5'h18;
    wmode(dip_pkg::MODE_DIGITAL, 12);
    for (i = 0; i < 600 && digital_video_locked !== 1'b1; i++)
      tick(1);
    chk("lock delay", 8'(i >= 244 && i < 600), 8'h01);
    if (i == 600)
      report_and_stop();
    rchk("link status", A_STA, 8'h18);
    run = 5'h10;
    wmode(dip_pkg::MODE_SEEK, TMO + 8);
    chk("lock", {7'h0, digital_video_locked}, 8'h00);
    run = 5'h00;
    $display("test link done");
  endtask

  task automatic t_both();
    run = 5'h19;
    wmode(dip_pkg::MODE_ANA_444, 12);
    wr(A_OVR, 8'h02);
    wmode(dip_pkg::MODE_DIGITAL, 4);
    wr(A_OVR, 8'h04);
    wmode(dip_pkg::MODE_ANA_444, 4);
    wr(A_OVR, 8'h07);
    wmode(dip_pkg::MODE_DIGITAL, 4);
    wr(A_OVR, 8'h05);
    wmode(dip_pkg::MODE_ANA_422, 4);
    run = 5'h00;
    wr(A_OVR, 8'h06);
    tick(TMO + 8);
    wmode(dip_pkg::MODE_DIGITAL, 1);
    wr(A_OVR, 8'h00);
    wmode(dip_pkg::MODE_SEEK, 4);
    $display("test both done");
  endtask

  task automatic t_pd();
    run = 5'h19;
    wr(A_OVR, 8'h06);
    wmode(dip_pkg::MODE_DIGITAL, 12);
    wr(A_PWR, 8'h00);
    wmode(dip_pkg::MODE_ABS_PD, 2);
    rchk("status", A_STA, 8'h00);
    rchk("power reg", A_PWR, 8'h00);
    wr(A_PWR, 8'h02);
    wmode(dip_pkg::MODE_DIGITAL, 12);
    run = 5'h00;
    wr(A_OVR, 8'h00);
    wmode(dip_pkg::MODE_SEEK, TMO + 8);
    $display("test power-down done");
  endtask

  initial
  begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    run = 5'h00;
    bad_count = 0;
    cmp_count = 0;
    tick(20);
    rst = 1'b0;
    tick(2);
    t_regs();
    t_analog();
    t_link();
    t_both();
    t_pd();
    report_and_stop();
  end
endmodule

/* File: verif/dip_src_model.sv */
// Behavioural video sources driving the sync, link clock and pixel-valid inputs.
module dip_src_model (
  input wire logic clk,
  input wire logic [4:0] run,
  output logic hsync_in,
  output logic vsync_in,
  output logic green_embedded_sync,
  output logic link_clk_in,
  output logic pixel_valid_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] cnt = 2'h0;

  initial
    {hsync_in, vsync_in, green_embedded_sync, link_clk_in, pixel_valid_flag} = 5'h00;

  // Each source toggles every two or every four cycles; a stopped one holds its level like an idle line.
  // The link clock runs at a quarter of the sampling clock, so no toggle is missed.
  always @(posedge clk)
  begin
    #1;
    cnt <= cnt + 2'h1;
    if (run[0] && cnt[0])
      hsync_in <= ~hsync_in;
    if (run[1] && cnt == 2'h0)
      vsync_in <= ~vsync_in;
    if (run[2] && cnt[0])
      green_embedded_sync <= ~green_embedded_sync;
    if (run[3] && cnt[0])
      link_clk_in <= ~link_clk_in;
    if (run[4] && cnt == 2'h0)
      pixel_valid_flag <= ~pixel_valid_flag;
  end
endmodule
